// [common/acc_sat_pkg.sv]
package acc_sat_pkg;

    // Accumulator and adder widths.
    localparam int ACC_W = 40;
    localparam int SIGN_BIT = 39;
    localparam int Q31_SIGN = 31;

    // Register port geometry.
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 2'h1;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 2'h2;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 2'h3;

    // Control register fields and reset value.
    localparam int CTRL_W = 4;
    localparam int CTRL_SAT_EN_A = 0;
    localparam int CTRL_SAT_EN_B = 1;
    localparam int CTRL_SAT32 = 2;
    localparam int CTRL_TRAP_EN = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

    // Status register (cpu_status_reg) fields.
    localparam int ST_SAT_A = 0;
    localparam int ST_SAT_B = 1;
    localparam int ST_OVF_A = 2;
    localparam int ST_OVF_B = 3;
    localparam int ST_ANY_OVF = 4;
    localparam int ST_ANY_SAT = 5;
    localparam int ST_TRAP = 6;

    // Interrupt events, shared by the status and mask registers.
    localparam int EV_W = 3;
    localparam int EV_SAT_A = 0;
    localparam int EV_SAT_B = 1;
    localparam int EV_OVF = 2;
    localparam logic [EV_W-1:0] IRQ_MASK_RESET = 3'h0;

    // Saturation limits, 9.31 and sign-extended 1.31.
    localparam logic [ACC_W-1:0] SAT40_POS = 40'h7fffffffff;
    localparam logic [ACC_W-1:0] SAT40_NEG = 40'h8000000000;
    localparam logic [ACC_W-1:0] SAT32_POS = 40'h007fffffff;
    localparam logic [ACC_W-1:0] SAT32_NEG = 40'hff80000000;

    // Saturation and overflow modes.
    typedef enum logic [2:0] {
        MODE_SAT40 = 3'b001,
        MODE_SAT32 = 3'b010,
        MODE_WRAP = 3'b100
    } sat_mode_t;

endpackage : acc_sat_pkg

// [design/sat_unit.sv]
`timescale 1ns/1ps

module sat_unit
    import acc_sat_pkg::*;
(
    // Adder result, one bit wider than an accumulator.
    input wire logic [ACC_W:0] sum_in,
    input wire sat_mode_t mode,
    // Value to load and overflow indications.
    output logic [ACC_W-1:0] value_out,
    output logic sat_hit,
    output logic ovf39,
    output logic beyond31,
    output logic guard_used
);

    logic [ACC_W-1:0] guard_probe;

    ////////////////////////////////////////////////////////////////////////////
    // Overflow detection and limit selection, purely combinational.
    always_comb begin
        ovf39 = sum_in[ACC_W] ^ sum_in[SIGN_BIT];
        beyond31 = !((&sum_in[ACC_W:Q31_SIGN]) || !(|sum_in[ACC_W:Q31_SIGN]));
        value_out = sum_in[ACC_W-1:0];
        sat_hit = 1'b0;
        unique case (mode) // see [RULE6]
            MODE_SAT40: begin
                sat_hit = ovf39; // see [RULE7]
                if (ovf39) begin
                    value_out = sum_in[ACC_W] ? SAT40_NEG : SAT40_POS; // see [RULE7]
                end
            end
            MODE_SAT32: begin
                sat_hit = beyond31; // see [RULE8]
                if (beyond31) begin
                    value_out = sum_in[ACC_W] ? SAT32_NEG : SAT32_POS; // see [RULE8]
                end
            end
            MODE_WRAP: begin
                // The sum wraps, so a large overflow loses its sign.
                sat_hit = ovf39; // see [RULE10]
            end
        endcase
        guard_probe = value_out;
        // Guard bits count only where the mode uses them.
        guard_used = (mode != MODE_SAT32) && // see [RULE9]
            !((&guard_probe[SIGN_BIT:Q31_SIGN]) || !(|guard_probe[SIGN_BIT:Q31_SIGN]));
    end

endmodule : sat_unit

// [design/acc_sat_logic.sv]
`timescale 1ns/1ps

// Functional notes
// [RULE1] Sticky saturation flags; only software clears them.
// [RULE2] Flag means range exceeded; saturate if enabled.
// [RULE3] Saturation off: flag follows bit 39 overflow.
// [RULE4] Trap enabled, saturation off: flag raises trap.
// [RULE5] Status shows OR of overflow and saturation.
// [RULE6] Exactly three modes: sat40, sat32, wrap.
// [RULE7] Sat40 loads 9.31 limit, sets flag.
// [RULE8] Sat32 loads extended 1.31 limit, sets flag.
// [RULE9] Sat32 never sets any overflow flag.
// [RULE10] Wrap mode: flag on bit 39, no saturation.
// [RULE11] Enable and width bits select the mode.
// [RULE12] Overflow flag recomputed per update from guard bits.
module acc_sat_logic
    import acc_sat_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Adder/subtractor result stream.
    input wire logic add_valid,
    input wire logic add_target,
    input wire logic [ACC_W:0] add_result,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output logic [DATA_W-1:0] reg_rd_data,
    // Accumulator contents.
    output logic [ACC_W-1:0] acc_a_value,
    output logic [ACC_W-1:0] acc_b_value,
    // Status and requests.
    output logic acc_a_sat_flag,
    output logic acc_b_sat_flag,
    output logic acc_a_ovf_flag,
    output logic acc_b_ovf_flag,
    output logic any_acc_ovf,
    output logic any_acc_sat,
    output logic trap_req,
    output logic irq
);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [ACC_W-1:0] acc_a;
        logic [ACC_W-1:0] acc_b;
        logic sat_a;
        logic sat_b;
        logic ovf_a;
        logic ovf_b;
        logic any_ovf;
        logic any_sat;
        logic trap;
        logic [EV_W-1:0] irq_stat;
        logic [EV_W-1:0] irq_mask;
        logic irq;
        logic [DATA_W-1:0] rd_data;
    } state_t;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    state_t state_reg;
    state_t state_next;
    sat_mode_t mode;
    logic target_sat_en;
    logic [ACC_W-1:0] sat_value;
    logic sat_hit;
    logic ovf39;
    logic beyond31;
    logic guard_used;
    logic [EV_W-1:0] events;
    logic [DATA_W-1:0] status_word;
    logic wr_ctrl;
    logic wr_status;
    logic wr_irq_stat;
    logic wr_irq_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; assertion stays asynchronous.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Mode of the write in flight, from the target's enable and the width bit.
    always_comb begin
        target_sat_en = add_target ? state_reg.ctrl[CTRL_SAT_EN_B]
                                   : state_reg.ctrl[CTRL_SAT_EN_A];
        if (!target_sat_en) begin
            mode = MODE_WRAP; // see [RULE3] see [RULE6] see [RULE11]
        end else if (state_reg.ctrl[CTRL_SAT32]) begin
            mode = MODE_SAT32; // see [RULE11]
        end else begin
            mode = MODE_SAT40; // see [RULE11]
        end
    end

    sat_unit u_sat (
        .sum_in(add_result),
        .mode(mode),
        .value_out(sat_value),
        .sat_hit(sat_hit),
        .ovf39(ovf39),
        .beyond31(beyond31),
        .guard_used(guard_used)
    );

    // Register decode.
    assign wr_ctrl = reg_wr_en && (reg_addr == REG_CTRL);
    assign wr_status = reg_wr_en && (reg_addr == REG_STATUS);
    assign wr_irq_stat = reg_wr_en && (reg_addr == REG_IRQ_STAT);
    assign wr_irq_mask = reg_wr_en && (reg_addr == REG_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Next state. Clears are applied first so that a set in the same cycle wins.
    always_comb begin
        state_next = state_reg;
        events = '0;
        status_word = '0;
        status_word[ST_SAT_A] = state_reg.sat_a;
        status_word[ST_SAT_B] = state_reg.sat_b;
        status_word[ST_OVF_A] = state_reg.ovf_a;
        status_word[ST_OVF_B] = state_reg.ovf_b;
        status_word[ST_ANY_OVF] = state_reg.any_ovf;
        status_word[ST_ANY_SAT] = state_reg.any_sat;
        status_word[ST_TRAP] = state_reg.trap;
        if (wr_ctrl) begin
            state_next.ctrl = reg_wr_data[CTRL_W-1:0];
        end
        if (wr_irq_mask) begin
            state_next.irq_mask = reg_wr_data[EV_W-1:0];
        end
        if (wr_irq_stat) begin
            state_next.irq_stat = state_reg.irq_stat & ~reg_wr_data[EV_W-1:0];
        end
        // Software is the only party that lowers a saturation flag.
        if (wr_status && reg_wr_data[ST_SAT_A]) begin
            state_next.sat_a = 1'b0; // see [RULE1]
        end
        if (wr_status && reg_wr_data[ST_SAT_B]) begin
            state_next.sat_b = 1'b0; // see [RULE1]
        end
        // Each pass through the adder loads the target, recomputes its overflow flag and can only set its saturation flag.
        if (add_valid && !add_target) begin
            state_next.acc_a = sat_value; // see [RULE2]
            state_next.ovf_a = guard_used; // see [RULE12]
            if (sat_hit) begin
                state_next.sat_a = 1'b1; // see [RULE1] see [RULE2]
            end
        end
        if (add_valid && add_target) begin
            state_next.acc_b = sat_value; // see [RULE2]
            state_next.ovf_b = guard_used; // see [RULE12]
            if (sat_hit) begin
                state_next.sat_b = 1'b1; // see [RULE1] see [RULE2]
            end
        end
        events[EV_SAT_A] = add_valid && !add_target && sat_hit;
        events[EV_SAT_B] = add_valid && add_target && sat_hit;
        events[EV_OVF] = add_valid && guard_used;
        state_next.irq_stat = state_next.irq_stat | events;
        state_next.any_ovf = state_next.ovf_a || state_next.ovf_b; // see [RULE5]
        state_next.any_sat = state_next.sat_a || state_next.sat_b; // see [RULE5]
        // With the trap enabled, the trap stays high while a flag is set and its accumulator wraps.
        state_next.trap = state_next.ctrl[CTRL_TRAP_EN] &&
            ((state_next.sat_a && !state_next.ctrl[CTRL_SAT_EN_A]) ||
             (state_next.sat_b && !state_next.ctrl[CTRL_SAT_EN_B])); // see [RULE4]
        state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
        // Read data stand for one cycle only and are zero otherwise.
        state_next.rd_data = '0;
        if (reg_rd_en) begin
            unique case (reg_addr)
                REG_CTRL: state_next.rd_data = {{(DATA_W-CTRL_W){1'b0}}, state_reg.ctrl};
                REG_STATUS: state_next.rd_data = status_word;
                REG_IRQ_STAT: state_next.rd_data = {{(DATA_W-EV_W){1'b0}}, state_reg.irq_stat};
                REG_IRQ_MASK: state_next.rd_data = {{(DATA_W-EV_W){1'b0}}, state_reg.irq_mask};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.ctrl <= CTRL_RESET;
            state_reg.irq_mask <= IRQ_MASK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs are plain views of state flops.
    assign reg_rd_data = state_reg.rd_data;
    assign acc_a_value = state_reg.acc_a;
    assign acc_b_value = state_reg.acc_b;
    assign acc_a_sat_flag = state_reg.sat_a;
    assign acc_b_sat_flag = state_reg.sat_b;
    assign acc_a_ovf_flag = state_reg.ovf_a;
    assign acc_b_ovf_flag = state_reg.ovf_b;
    assign any_acc_ovf = state_reg.any_ovf;
    assign any_acc_sat = state_reg.any_sat;
    assign trap_req = state_reg.trap;
    assign irq = state_reg.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the flag, saturation and trap behaviour.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sticky_sat_a: assert property ( // see [RULE1]
        acc_a_sat_flag && !(wr_status && reg_wr_data[ST_SAT_A]) |=> acc_a_sat_flag)
        else $error("Saturation flag A dropped without a software clear.");

    flag_meaning_a: assert property ( // see [RULE2]
        add_valid && !add_target && mode == MODE_SAT40 && ovf39
        |=> acc_a_sat_flag && (acc_a_value == SAT40_POS || acc_a_value == SAT40_NEG))
        else $error("Range overflow did not saturate accumulator A.");

    wrap_flag_b_a: assert property ( // see [RULE3]
        add_valid && add_target && !state_reg.ctrl[CTRL_SAT_EN_B] && ovf39
        |=> acc_b_sat_flag)
        else $error("Bit 39 overflow with saturation off left flag B clear.");

    trap_raise_a: assert property ( // see [RULE4]
        trap_req == (state_reg.ctrl[CTRL_TRAP_EN] &&
            ((acc_a_sat_flag && !state_reg.ctrl[CTRL_SAT_EN_A]) ||
             (acc_b_sat_flag && !state_reg.ctrl[CTRL_SAT_EN_B]))))
        else $error("Trap request disagrees with flags and enables.");

    combined_bits_a: assert property ( // see [RULE5]
        any_acc_sat == (acc_a_sat_flag || acc_b_sat_flag) &&
        any_acc_ovf == (acc_a_ovf_flag || acc_b_ovf_flag))
        else $error("Combined status bits are not the OR of the flags.");

    mode_onehot_a: assert property ( // see [RULE6]
        $onehot(mode))
        else $error("Saturation mode is not one of the three.");

    sat40_limit_a: assert property ( // see [RULE7]
        add_valid && add_target && mode == MODE_SAT40 && ovf39 && !add_result[ACC_W]
        |=> acc_b_value == SAT40_POS)
        else $error("Positive 40-bit saturation loaded a wrong value.");

    sat32_limit_a: assert property ( // see [RULE8]
        add_valid && !add_target && mode == MODE_SAT32 && beyond31 && add_result[ACC_W]
        |=> acc_a_value == SAT32_NEG && acc_a_sat_flag)
        else $error("Negative 32-bit saturation loaded a wrong value.");

    sat32_no_ovf_a: assert property ( // see [RULE9]
        add_valid && !add_target && mode == MODE_SAT32 |=> !acc_a_ovf_flag)
        else $error("Overflow flag A set under 32-bit saturation.");

    wrap_value_a: assert property ( // see [RULE10]
        add_valid && !add_target && mode == MODE_WRAP
        |=> acc_a_value == $past(add_result[ACC_W-1:0]))
        else $error("Wrap mode altered the adder result.");

    mode_select_a: assert property ( // see [RULE11]
        !target_sat_en |-> mode == MODE_WRAP)
        else $error("Saturation disabled yet a saturating mode chosen.");

    ovf_refresh_a: assert property ( // see [RULE12]
        add_valid && add_target && mode == MODE_SAT40 && beyond31 && !ovf39
        |=> acc_b_ovf_flag ##1 ($past(add_valid && add_target) || acc_b_ovf_flag))
        else $error("Guard-bit overflow did not set flag B.");

    irq_level_a: assert property (
        irq == |(state_reg.irq_stat & state_reg.irq_mask))
        else $error("Interrupt output disagrees with status and mask.");

    // Flag B is as sticky as flag A; only its own clear bit may lower it.
    sticky_sat_b_a: assert property ( // see [RULE1]
        acc_b_sat_flag && !(wr_status && reg_wr_data[ST_SAT_B]) |=> acc_b_sat_flag)
        else $error("Saturation flag B dropped without a software clear.");

    // A software clear in the same cycle as a saturation must lose.
    set_wins_a: assert property ( // see [RULE1]
        add_valid && !add_target && sat_hit |=> acc_a_sat_flag)
        else $error("Saturation event on A did not leave flag A set.");

    sat40_neg_a: assert property ( // see [RULE7]
        add_valid && !add_target && mode == MODE_SAT40 && ovf39 && add_result[ACC_W]
        |=> acc_a_value == SAT40_NEG)
        else $error("Negative 40-bit saturation loaded a wrong value.");

    sat32_clean_b_a: assert property ( // see [RULE9]
        add_valid && add_target && mode == MODE_SAT32 |=> !acc_b_ovf_flag)
        else $error("Overflow flag B set under 32-bit saturation.");

    wrap_value_b_a: assert property ( // see [RULE10]
        add_valid && add_target && mode == MODE_WRAP
        |=> acc_b_value == $past(add_result[ACC_W-1:0]))
        else $error("Wrap mode altered the adder result on B.");

    // An in-range update must drop a stale overflow flag, not keep it.
    ovf_clear_a: assert property ( // see [RULE12]
        add_valid && !add_target && !guard_used |=> !acc_a_ovf_flag)
        else $error("Overflow flag A kept after an in-range update.");

    cover_sat40: cover property (
        add_valid && mode == MODE_SAT40 && ovf39 ##1 any_acc_sat);
    cover_sat32: cover property (
        add_valid && mode == MODE_SAT32 && beyond31 ##1 any_acc_sat);
    cover_trap: cover property (
        add_valid && mode == MODE_WRAP && ovf39 ##1 trap_req);
    cover_clear: cover property (
        acc_a_sat_flag ##1 wr_status ##1 !acc_a_sat_flag);

endmodule : acc_sat_logic

// [verif/adder_source.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Far side model: instruction control feeding one adder result at a time.
module adder_source
    import acc_sat_pkg::*;
(
    // Clock.
    input wire logic sys_clk,
    // Result stream toward the saturation logic.
    output logic add_valid,
    output logic add_target,
    output logic [ACC_W:0] add_result
);

    // Idle values at time zero.
    initial begin
        add_valid = 1'b0;
        add_target = 1'b0;
        add_result = '0;
    end

    // One result per call, held for exactly the edge that takes it.
    // Afterwards the bus shows the inverse, so a stale value is never taken for a new one.
    task automatic push(input logic target, input logic [ACC_W:0] result);
        @(posedge sys_clk);
        add_valid <= 1'b1;
        add_target <= target;
        add_result <= result;
        @(posedge sys_clk);
        add_valid <= 1'b0;
        add_target <= ~target;
        add_result <= ~result;
    endtask : push

endmodule : adder_source

// [verif/testbench.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the accumulator saturation logic.
module testbench;
    import acc_sat_pkg::*;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wr_data = '0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [DATA_W-1:0] reg_rd_data;
    logic add_valid, add_target;
    logic [ACC_W:0] add_result;
    logic [ACC_W-1:0] acc_a_value, acc_b_value;
    logic acc_a_sat_flag, acc_b_sat_flag, acc_a_ovf_flag, acc_b_ovf_flag;
    logic any_acc_ovf, any_acc_sat, trap_req, irq;
    int err_total = 0;
    int cmp_count = 0;

    // Clock at 40 MHz.
    always #12.5 sys_clk = ~sys_clk;

    adder_source src (.sys_clk(sys_clk), .add_valid(add_valid), .add_target(add_target),
        .add_result(add_result));

    acc_sat_logic dut (.sys_clk(sys_clk), .reset_n(reset_n), .add_valid(add_valid),
        .add_target(add_target), .add_result(add_result), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .acc_a_value(acc_a_value), .acc_b_value(acc_b_value),
        .acc_a_sat_flag(acc_a_sat_flag), .acc_b_sat_flag(acc_b_sat_flag),
        .acc_a_ovf_flag(acc_a_ovf_flag), .acc_b_ovf_flag(acc_b_ovf_flag),
        .any_acc_ovf(any_acc_ovf), .any_acc_sat(any_acc_sat), .trap_req(trap_req), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic chk(input string what, input logic [ACC_W-1:0] exp,
        input logic [ACC_W-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // A write is one strobe cycle; it takes effect at the edge that samples it.
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so sample just there.
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1;
        chk(what, {32'h0, e}, {32'h0, reg_rd_data});
    endtask : rd_chk

    // Flag pins in status register order, then the same bits through the register.
    task automatic flags(input logic [6:0] e);
        chk("flag pins", {33'h0, e}, {33'h0, trap_req, any_acc_sat, any_acc_ovf, acc_b_ovf_flag,
            acc_a_ovf_flag, acc_b_sat_flag, acc_a_sat_flag});
        rd_chk("status", REG_STATUS, {1'b0, e});
    endtask : flags

    task automatic run(input logic t, input logic [ACC_W:0] r);
        src.push(t, r);
        #1;
    endtask : run

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_chk("ctrl", REG_CTRL, 8'h00);
        rd_chk("mask", REG_IRQ_MASK, 8'h00);
        flags(7'h00);
        // Full 40-bit saturation on A, both directions.
        wr_reg(REG_CTRL, 8'h01);
        run(1'b0, 41'h08000000000);
        chk("acc_a_value", SAT40_POS, acc_a_value);
        flags(7'h35);
        run(1'b0, 41'h17fffffffff);
        chk("acc_a_value", SAT40_NEG, acc_a_value);
        // In-range result: sat flag sticks, overflow flag recomputed.
        run(1'b0, 41'h00000000010);
        chk("acc_a_value", 40'h0000000010, acc_a_value);
        flags(7'h21);
        wr_reg(REG_STATUS, 8'h01);
        flags(7'h00);
        // Interrupt: events latched, masked, then cleared.
        rd_chk("irq_stat", REG_IRQ_STAT, 8'h05);
        chk("irq", 40'h0, {39'h0, irq});
        wr_reg(REG_IRQ_MASK, 8'h05);
        @(posedge sys_clk);
        #1;
        chk("irq", 40'h1, {39'h0, irq});
        wr_reg(REG_IRQ_STAT, 8'h05);
        @(posedge sys_clk);
        #1;
        chk("irq", 40'h0, {39'h0, irq});
        // 32-bit saturation on B never flags overflow.
        wr_reg(REG_CTRL, 8'h06);
        run(1'b1, 41'h00080000000);
        chk("acc_b_value", SAT32_POS, acc_b_value);
        flags(7'h22);
        run(1'b1, 41'h1ff7fffffff);
        chk("acc_b_value", SAT32_NEG, acc_b_value);
        flags(7'h22);
        wr_reg(REG_STATUS, 8'h02);
        // Wrap mode with trap enabled on A: no saturation, flag and trap raised.
        wr_reg(REG_CTRL, 8'h08);
        run(1'b0, 41'h08000000000);
        chk("acc_a_value", 40'h8000000000, acc_a_value);
        chk("acc_b_value", SAT32_NEG, acc_b_value);
        flags(7'h75);
        wr_reg(REG_CTRL, 8'h00);
        @(posedge sys_clk);
        #1;
        flags(7'h35);
        // Wrap mode on B without trap: sign lost, flag set from bit 39.
        run(1'b1, 41'h10000000000);
        chk("acc_b_value", 40'h0000000000, acc_b_value);
        flags(7'h37);
        // Guard bits used on B under 40-bit saturation: no saturation, but overflow.
        wr_reg(REG_CTRL, 8'h0a);
        run(1'b1, 41'h00080000000);
        chk("acc_b_value", 40'h0080000000, acc_b_value);
        flags(7'h7f);
        // Trap now held up by flag B alone, whose accumulator wraps.
        wr_reg(REG_STATUS, 8'h01);
        wr_reg(REG_CTRL, 8'h09);
        flags(7'h7e);
        give_verdict();
    end

endmodule : testbench
